// >>> rtl/rcf_pkg.sv
// constants for the reset-cause flag register block
package rcf_pkg;
   // register map (wishbone byte addresses)
   localparam logic [3:0] ADDR_CAUSE = 4'h0;
   localparam logic [3:0] ADDR_CLK = 4'h4;
   localparam logic [3:0] ADDR_WDT = 4'h8;
   // field positions in reset_cause_status
   localparam int BIT_POR = 0;
   localparam int BIT_BROWNOUT = 1;
   localparam int BIT_IDLE = 2;
   localparam int BIT_SLEEP = 3;
   localparam int BIT_WDT_TIMEOUT = 4;
   localparam int BIT_WDT_EN = 5;
   localparam int BIT_SOFT = 6;
   localparam int BIT_PIN = 7;
   localparam int BIT_VREG = 8;
   localparam int BIT_ILL = 14;
   localparam int BIT_TRAP = 15;
   // writable bits; 13..9 are unimplemented
   localparam logic [15:0] CAUSE_WMASK = 16'hC1FF;
   // value after power-on: power-on and brown-out flags set
   localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;
   // brown-out keeps pin flag, power-on flag and the two controls
   localparam logic [15:0] CAUSE_BROWNOUT_KEEP = 16'h01A1;
   localparam logic [2:0] OSC_RESET_VAL = 3'h0;
endpackage

// >>> rtl/rcf_reset_cause.sv
// reset-cause flag register with wishbone slave
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
// =====================================================================
// Overview of operation
// - each reset source sets its own flag in the cause register.
// - a power-on reset clears every flag except the power-on and brown-out flags.
// - power-on sets bit 0, and brown-out or power-on sets bit 1.
// - trap, illegal-access and soft flags clear on power-on or brown-out, the pin flag on power-on only.
// - sleep/idle set by power-save entry; watchdog flag set on expiry, cleared by power-save, power-on or brown-out.
// - software may set or clear any flag by a plain write; a hardware event in the same cycle wins over it.
// - writing a one into a flag never causes a reset.
// - fuse at 1 keeps watchdog on; at 0 bit 5 enables it.
// - bit 8 drives the regulator standby output and keeps the last write until power-on.
// - with clock switching off, reset clock source comes from the config bits.
module rcf_reset_cause (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // reset and event pulses, same clock domain
   input wire logic por_evt_i,
   input wire logic brownout_evt_i,
   input wire logic master_clear_pin_evt_i,
   input wire logic soft_reset_evt_i,
   input wire logic wdt_expire_evt_i,
   input wire logic trap_conflict_evt_i,
   input wire logic illegal_access_evt_i,
   input wire logic sleep_entry_evt_i,
   input wire logic idle_entry_evt_i,
   // configuration
   input wire logic watchdog_fuse_enable_i,
   input wire logic clock_switch_en_i,
   input wire logic [2:0] osc_config_i,
   input wire logic [2:0] osc_current_i,
   // outputs
   output logic watchdog_run_o,
   output logic regulator_standby_ctl_o,
   output logic [2:0] osc_select_o
);
   logic [15:0] cause_q;
   logic [15:0] cause_d;
   logic [2:0] osc_q;
   logic ack_q;
   logic req;
   logic hit;
   logic wr_cause;
   logic [15:0] wmask;
   logic sys_reset;
   logic other_evt;

   // =====================================================================
   // bus decode
   assign req = wb_cyc_i && wb_stb_i && !ack_q && !wb_err_o; // err also ends the request, no double answer
   assign hit = (wb_adr_i == rcf_pkg::ADDR_CAUSE) || (wb_adr_i == rcf_pkg::ADDR_CLK)
      || (wb_adr_i == rcf_pkg::ADDR_WDT);
   // write lands at the edge where the master samples ack
   assign wr_cause = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && (wb_adr_i == rcf_pkg::ADDR_CAUSE);
   assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & rcf_pkg::CAUSE_WMASK;
   assign sys_reset = por_evt_i | brownout_evt_i | master_clear_pin_evt_i | soft_reset_evt_i
      | wdt_expire_evt_i | trap_conflict_evt_i | illegal_access_evt_i;
   // events other than power-on and brown-out, used by the assertions
   assign other_evt = master_clear_pin_evt_i | soft_reset_evt_i | wdt_expire_evt_i | trap_conflict_evt_i
      | illegal_access_evt_i | sleep_entry_evt_i | idle_entry_evt_i;

   // =====================================================================
   // next cause value: software write first, then hardware events win
   always_comb begin
      cause_d = cause_q;
      if (wr_cause) begin
         cause_d = (cause_q & ~wmask) | (wb_dat_i[15:0] & wmask);
      end
      // writes only store bits; nothing here feeds a reset source
      if (power_save_any()) begin
         cause_d[rcf_pkg::BIT_WDT_TIMEOUT] = 1'b0;
      end
      if (sleep_entry_evt_i) begin
         cause_d[rcf_pkg::BIT_SLEEP] = 1'b1;
      end
      if (idle_entry_evt_i) begin
         cause_d[rcf_pkg::BIT_IDLE] = 1'b1;
      end
      if (brownout_evt_i || por_evt_i) begin
         cause_d = cause_d & rcf_pkg::CAUSE_BROWNOUT_KEEP;
         cause_d[rcf_pkg::BIT_BROWNOUT] = 1'b1;
      end
      if (por_evt_i) begin
         cause_d = rcf_pkg::CAUSE_POR_VAL;
      end
      if (master_clear_pin_evt_i) begin
         cause_d[rcf_pkg::BIT_PIN] = 1'b1;
      end
      if (soft_reset_evt_i) begin
         cause_d[rcf_pkg::BIT_SOFT] = 1'b1;
      end
      if (wdt_expire_evt_i) begin
         cause_d[rcf_pkg::BIT_WDT_TIMEOUT] = 1'b1;
      end
      if (trap_conflict_evt_i) begin
         cause_d[rcf_pkg::BIT_TRAP] = 1'b1;
      end
      if (illegal_access_evt_i) begin
         cause_d[rcf_pkg::BIT_ILL] = 1'b1;
      end
   end

   function automatic logic power_save_any();
      return sleep_entry_evt_i | idle_entry_evt_i;
   endfunction

   // =====================================================================
   // cause register; rst_i loads the power-on image
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_q <= rcf_pkg::CAUSE_POR_VAL;
      end else begin
         cause_q <= cause_d;
      end
   end

   // oscillator selection kept from the current source across non power resets with clock switching on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_q <= rcf_pkg::OSC_RESET_VAL;
      end else if (!clock_switch_en_i && sys_reset) begin
         osc_q <= osc_config_i;
      end else if (por_evt_i || brownout_evt_i) begin
         osc_q <= osc_config_i;
      end else if (sys_reset) begin
         osc_q <= osc_current_i;
      end
   end

   // bus answer one cycle after request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         ack_q <= req && hit;
         wb_err_o <= req && !hit;
         wb_dat_o <= 32'h00000000;
         if (req && !wb_we_i) begin
            case (wb_adr_i)
               rcf_pkg::ADDR_CAUSE: wb_dat_o <= {16'h0000, cause_q};
               rcf_pkg::ADDR_CLK: wb_dat_o <= {29'h0000000, osc_q};
               rcf_pkg::ADDR_WDT: wb_dat_o <= {31'h0000000, watchdog_run_o};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   // =====================================================================
   // outputs
   assign wb_ack_o = ack_q;
   assign watchdog_run_o = watchdog_fuse_enable_i | cause_q[rcf_pkg::BIT_WDT_EN];
   assign regulator_standby_ctl_o = cause_q[rcf_pkg::BIT_VREG];
   assign osc_select_o = osc_q;

   // =====================================================================
   // assertions
   // a lone power-on pulse leaves exactly the power-on image; same-cycle reset events add their flags, sleep/idle flags are lost
   a_por_image: assert property (@(posedge clk_i) disable iff (rst_i)
      (por_evt_i && !other_evt) |=> cause_q == rcf_pkg::CAUSE_POR_VAL) else $error("power-on image wrong");
   a_brownout_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      brownout_evt_i |=> cause_q[rcf_pkg::BIT_BROWNOUT] && (!cause_q[rcf_pkg::BIT_SOFT] || $past(soft_reset_evt_i)))
      else $error("brown-out flag wrong");
   // each reset source leaves its own flag set one cycle later
   a_pin_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      master_clear_pin_evt_i |=> cause_q[rcf_pkg::BIT_PIN]) else $error("pin flag not set");
   a_soft_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      soft_reset_evt_i |=> cause_q[rcf_pkg::BIT_SOFT]) else $error("soft reset flag not set");
   a_trap_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      trap_conflict_evt_i |=> cause_q[rcf_pkg::BIT_TRAP]) else $error("trap flag not set");
   a_ill_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      illegal_access_evt_i |=> cause_q[rcf_pkg::BIT_ILL]) else $error("illegal-access flag not set");
   a_timeout_set: assert property (@(posedge clk_i) disable iff (rst_i)
      wdt_expire_evt_i |=> cause_q[rcf_pkg::BIT_WDT_TIMEOUT]) else $error("time-out flag not set");
   // power-save entry clears the time-out flag; a same-cycle expiry or power-type reset decides instead
   a_timeout_clr: assert property (@(posedge clk_i) disable iff (rst_i)
      (sleep_entry_evt_i && !wdt_expire_evt_i && !por_evt_i && !brownout_evt_i)
      |=> !cause_q[rcf_pkg::BIT_WDT_TIMEOUT] && cause_q[rcf_pkg::BIT_SLEEP])
      else $error("power-save flags wrong");
   a_idle_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (idle_entry_evt_i && !por_evt_i && !brownout_evt_i) |=> cause_q[rcf_pkg::BIT_IDLE]) else $error("idle flag not set");
   // brown-out alone: event flags gone next cycle, pin flag, power-on flag and controls kept
   sequence s_brownout_only;
      brownout_evt_i && !por_evt_i && !other_evt;
   endsequence
   sequence s_brownout_cleared;
      (cause_q & ~rcf_pkg::CAUSE_BROWNOUT_KEEP) == (16'h0001 << rcf_pkg::BIT_BROWNOUT);
   endsequence
   a_brownout_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      s_brownout_only |=> s_brownout_cleared) else $error("brown-out left flags set");
   a_pin_kept: assert property (@(posedge clk_i) disable iff (rst_i)
      s_brownout_only ##0 !wr_cause |=> cause_q[rcf_pkg::BIT_PIN] == $past(cause_q[rcf_pkg::BIT_PIN])
      && cause_q[rcf_pkg::BIT_POR] == $past(cause_q[rcf_pkg::BIT_POR]))
      else $error("brown-out lost pin or power-on flag");
   // controls and storage bits
   a_wdt_run: assert property (@(posedge clk_i) disable iff (rst_i)
      watchdog_fuse_enable_i |-> watchdog_run_o) else $error("watchdog not forced on");
   a_resv_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      cause_q[13:9] == 5'h00) else $error("reserved bits not zero");
   a_sw_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_cause && wb_sel_i[1] && !sys_reset && !power_save_any())
      |=> cause_q[rcf_pkg::BIT_VREG] == $past(wb_dat_i[8])) else $error("write not stored");
   // clock source: configuration bits with switching off, else by reset kind
   a_osc_config: assert property (@(posedge clk_i) disable iff (rst_i)
      (!clock_switch_en_i && sys_reset) |=> osc_q == $past(osc_config_i)) else $error("oscillator not from config");
   a_osc_keep: assert property (@(posedge clk_i) disable iff (rst_i)
      (clock_switch_en_i && soft_reset_evt_i && !por_evt_i && !brownout_evt_i)
      |=> osc_q == $past(osc_current_i)) else $error("oscillator not kept");
endmodule

// >>> sim/test_reset_cause_flag_register.sv
// self-checking bench for the reset-cause flag register
`timescale 1ns/10ps
module test_reset_cause_flag_register;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fuse = 1'b0, csw = 1'b1;
   logic [3:0] adr = 4'h0;
   logic [31:0] dw = 32'h0, dr;
   logic [8:0] ev = 9'h000;
   logic [2:0] ocfg = 3'h5, ocur = 3'h2, osel;
   logic ack, err, wrun, vreg, er;
   logic [3:0] sel = 4'h0, lanes = 4'hF;
   int err_total = 0, total_checks = 0;
   // rows: start value, event pulses (idle,sleep,ill,trap,wdt,soft,pin,brownout,por), expected value
   localparam logic [40:0] ROWS [12] = '{
      {16'h0000, 9'h004, 16'h0080}, {16'h0000, 9'h008, 16'h0040}, {16'h0000, 9'h010, 16'h0010},
      {16'h0000, 9'h020, 16'h8000}, {16'h0000, 9'h040, 16'h4000}, {16'h0000, 9'h080, 16'h0008},
      {16'h0000, 9'h100, 16'h0004}, {16'h0010, 9'h080, 16'h0008}, {16'hC1FF, 9'h002, 16'h01A3},
      {16'hC1FF, 9'h001, 16'h0003}, {16'hFFFF, 9'h000, 16'hC1FF}, {16'h80C0, 9'h000, 16'h80C0}};
   // ===================================================
   // clock and design
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   rcf_reset_cause uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .wb_err_o(err),
      .por_evt_i(ev[0]), .brownout_evt_i(ev[1]), .master_clear_pin_evt_i(ev[2]), .soft_reset_evt_i(ev[3]),
      .wdt_expire_evt_i(ev[4]), .trap_conflict_evt_i(ev[5]), .illegal_access_evt_i(ev[6]),
      .sleep_entry_evt_i(ev[7]), .idle_entry_evt_i(ev[8]), .watchdog_fuse_enable_i(fuse),
      .clock_switch_en_i(csw), .osc_config_i(ocfg), .osc_current_i(ocur), .watchdog_run_o(wrun),
      .regulator_standby_ctl_o(vreg), .osc_select_o(osel));
   // ===================================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // classic cycle; waits for ack or err under a bound, data taken at that edge
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d;
      sel <= lanes;
      do begin
         @(posedge clk_i);
         n++;
      end while (!(ack === 1'b1 || err === 1'b1) && n < 20);
      q = dr;
      er = err;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      sel <= 4'h0;
      if (n >= 20) chk(32'h0, 32'h1);
   endtask
   task automatic pulse(input logic [8:0] e);
      @(posedge clk_i) ev <= e;
      @(posedge clk_i) ev <= 9'h000;
      @(posedge clk_i);
   endtask
   task automatic end_of_test;
      if (err_total == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog: the whole run is under two hundred cycles
   initial begin
      #100000;
      err_total++;
      end_of_test();
   end
   // ===================================================
   // main sequence
   initial begin
      logic [31:0] q;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, rcf_pkg::ADDR_CAUSE, 32'h0, q);
      chk(q, 32'h0003);
      chk({31'h0, er}, 32'h0);
      chk({29'h0, osel}, {29'h0, rcf_pkg::OSC_RESET_VAL});
      for (int i = 0; i < 12; i++) begin
         wb(1'b1, rcf_pkg::ADDR_CAUSE, {16'h0, ROWS[i][40:25]}, q);
         pulse(ROWS[i][24:16]);
         wb(1'b0, rcf_pkg::ADDR_CAUSE, 32'h0, q);
         chk(q, {16'h0, ROWS[i][15:0]});
      end
      // clock source by reset kind, switching on then off
      pulse(9'h004);
      chk({29'h0, osel}, 32'h2);
      pulse(9'h002);
      chk({29'h0, osel}, 32'h5);
      @(posedge clk_i) csw <= 1'b0;
      ocfg <= 3'h6;
      pulse(9'h004);
      chk({29'h0, osel}, 32'h6);
      // software watchdog enable only counts with the fuse low
      wb(1'b1, rcf_pkg::ADDR_CAUSE, 32'h0120, q);
      @(posedge clk_i);
      chk({30'h0, wrun, vreg}, 32'h3);
      wb(1'b1, rcf_pkg::ADDR_CAUSE, 32'h0000, q);
      @(posedge clk_i);
      chk({30'h0, wrun, vreg}, 32'h0);
      @(posedge clk_i) fuse <= 1'b1;
      @(posedge clk_i);
      @(posedge clk_i);
      chk({31'h0, wrun}, 32'h1);
      // unmapped address answers with err and writes nothing
      wb(1'b1, 4'hC, 32'hFFFF, q);
      chk({31'h0, er}, 32'h1);
      wb(1'b0, rcf_pkg::ADDR_CAUSE, 32'h0, q);
      chk(q, 32'h0);
      // byte lanes: the low lane alone, then the high lane alone
      lanes = 4'h1;
      wb(1'b1, rcf_pkg::ADDR_CAUSE, 32'hFFFF, q);
      wb(1'b0, rcf_pkg::ADDR_CAUSE, 32'h0, q);
      chk(q, 32'h00FF);
      lanes = 4'h2;
      wb(1'b1, rcf_pkg::ADDR_CAUSE, 32'hFF00, q);
      lanes = 4'hF;
      wb(1'b0, rcf_pkg::ADDR_CAUSE, 32'h0, q);
      chk(q, 32'hC1FF);
      // reset again in mid-run: power-on image and reset clock source come back
      @(posedge clk_i) rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({29'h0, osel}, {29'h0, rcf_pkg::OSC_RESET_VAL});
      chk({30'h0, wrun, vreg}, 32'h2);
      wb(1'b0, rcf_pkg::ADDR_CAUSE, 32'h0, q);
      chk(q, 32'h0003);
      end_of_test();
   end
endmodule
